//--- nvac_pkg.sv
// Package: register map, control bit positions, timing for nv access control
package nvac_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [4:0] OFF_DATA_LOW  = 5'h00;
	localparam logic [4:0] OFF_DATA_HIGH = 5'h04;
	localparam logic [4:0] OFF_ADDR_LOW  = 5'h08;
	localparam logic [4:0] OFF_ADDR_HIGH = 5'h0C;
	localparam logic [4:0] OFF_CONTROL   = 5'h10;
	localparam logic [4:0] OFF_UNLOCK    = 5'h14;
	localparam logic [4:0] OFF_IRQ_FLAGS = 5'h18;
	localparam logic [4:0] OFF_IRQ_ENAB  = 5'h1C;
	// Control bit positions
	localparam int CB_PGM  = 7;
	localparam int CB_CFG  = 6;
	localparam int CB_LATCH_LOAD_ONLY = 5;
	localparam int CB_ERS  = 4;
	localparam int CB_ERR  = 3;
	localparam int CB_WEN  = 2;
	localparam int CB_WR   = 1;
	localparam int CB_RD   = 0;
	// Interrupt flag / enable position
	localparam int IRQ_DONE_BIT = 4;
	// Fixed read-as values
	localparam logic [7:0] ADDR_HIGH_TOP = 8'h80;
	localparam logic [7:0] DATA_HIGH_MASK = 8'h3F;
	localparam logic [6:0] ADDR_HIGH_MASK = 7'h7F;
	// Unlock pattern
	localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
	// Configuration space map
	localparam logic [14:0] CFG_UID_LO  = 15'h0000;
	localparam logic [14:0] CFG_UID_HI  = 15'h0003;
	localparam logic [14:0] CFG_DEVID   = 15'h0006;
	localparam logic [14:0] CFG_WORD_LO = 15'h0007;
	localparam logic [14:0] CFG_WORD_HI = 15'h0008;
	localparam int CFG_DEPTH = 9;
	// Array sizes
	localparam int PGM_DEPTH = 256;
	localparam int EE_DEPTH  = 256;
	localparam int LATCH_WORDS = 8;
	// Program/erase time
	localparam int CLK_MHZ   = 250;
	localparam int PROG_TIME_US = 2000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	// Identity word, value is arbitrary
	localparam logic [13:0] DEVICE_ID_WORD = 14'h1234;
	// Operation kinds
	typedef enum logic [2:0] {
		OP_NONE  = 3'b001,
		OP_READ  = 3'b010,
		OP_WRITE = 3'b100
	} nvac_op_t;
endpackage : nvac_pkg

//--- nvac_store.sv
// Nonvolatile storage model: flash, data EEPROM and configuration words
module nvac_store
	import nvac_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Access request
	input  wire logic        rd_pulse,
	input  wire logic        latch_pulse,
	input  wire logic        commit_pulse,
	input  wire logic        erase_sel,
	input  wire logic        pgm_sel,
	input  wire logic        cfg_sel,
	input  wire logic [14:0] addr,
	input  wire logic [13:0] wdata,
	// Read answer
	output logic      [13:0] rdata,
	output logic             addr_ok
);
	logic [13:0] pgm_mem [PGM_DEPTH];
	logic [7:0]  ee_mem  [EE_DEPTH];
	logic [13:0] cfg_mem [CFG_DEPTH];
	logic [13:0] latch_reg [LATCH_WORDS];
	logic [14:0] row_reg;

	function automatic logic cfg_writable(input logic [14:0] a);
		return a <= CFG_UID_HI;
	endfunction : cfg_writable

	function automatic logic cfg_readable(input logic [14:0] a);
		return cfg_writable(a) || a == CFG_DEVID ||
			(a >= CFG_WORD_LO && a <= CFG_WORD_HI);
	endfunction : cfg_readable

	always_comb begin
		addr_ok = 1'b1;
		rdata   = 14'h0000;
		if (!rd_pulse) begin
			addr_ok = 1'b0;
		end else if (cfg_sel) begin
			addr_ok = cfg_readable(addr);
			if (addr == CFG_DEVID)
				rdata = DEVICE_ID_WORD;
			else if (addr_ok)
				rdata = cfg_mem[addr[3:0]];
		end else if (pgm_sel) begin
			rdata = pgm_mem[addr[7:0]];
		end else begin
			rdata = {6'h00, ee_mem[addr[7:0]]};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < LATCH_WORDS; i++)
				latch_reg[i] <= 14'h3FFF;
			row_reg <= '0;
		end else if (latch_pulse) begin
			latch_reg[addr[2:0]] <= wdata;
			row_reg              <= addr;
		end else if (commit_pulse && !erase_sel) begin
			for (int i = 0; i < LATCH_WORDS; i++)
				latch_reg[i] <= 14'h3FFF;
		end
	end

	// Arrays hold contents across reset
	always_ff @(posedge clk) begin
		if (commit_pulse) begin
			if (!cfg_sel && !pgm_sel) begin
				ee_mem[addr[7:0]] <= wdata[7:0];
			end else if (cfg_sel) begin
				for (int i = 0; i < LATCH_WORDS; i++)
					if (cfg_writable(15'(i)) && cfg_writable(addr))
						cfg_mem[i] <= erase_sel ? 14'h3FFF : latch_reg[i];
			end else begin
				// Erase targets the addressed row, programming the latched one
				for (int i = 0; i < LATCH_WORDS; i++)
					if (erase_sel)
						pgm_mem[{addr[7:3], 3'(i)}] <= 14'h3FFF;
					else
						pgm_mem[{row_reg[7:3], 3'(i)}] <= latch_reg[i];
			end
		end
	end
endmodule : nvac_store

//--- nvac_top.sv
// Nonvolatile memory access control with AXI4-Lite register port
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
module nvac_top
	import nvac_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// CPU side
	output logic             cpu_halt,
	output logic             irq
);
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		UNLOCK_IDLE = 3'b001,
		UNLOCK_HALF = 3'b010,
		UNLOCK_OPEN = 3'b100
	} nvac_unlock_t;

	logic [7:0]  data_low_reg;
	logic [5:0]  data_high_reg;
	logic [7:0]  addr_low_reg;
	logic [6:0]  addr_high_reg;
	logic [7:0]  control_reg;
	logic [7:0]  irq_flags_reg;
	logic [7:0]  irq_enab_reg;
	nvac_unlock_t unlock_reg;
	logic [31:0] busy_cnt_reg;
	logic        busy_reg;
	logic        aw_held_reg;
	logic        aw_ok_reg;
	logic        w_held_reg;
	logic [4:0]  aw_addr_reg;
	logic [7:0]  w_data_reg;
	logic        w_lane_reg;
	logic        done_pulse;
	logic        commit_pulse;
	logic        latch_pulse;
	logic        wr_req;
	logic        rd_pulse;
	logic        wr_fire;
	logic        rd_fire;
	logic [13:0] st_rdata;
	logic        st_addr_ok;
	logic [14:0] nv_addr;
	logic        pgm_sel;
	logic        real_write;

	function automatic logic [4:0] word_off(input logic [31:0] a);
		return {a[4:2], 2'b00};
	endfunction : word_off

	// Full address checked so that high offsets do not alias low ones
	function automatic logic known_off(input logic [31:0] a);
		return a[31:5] == 27'h0 && word_off(a) <= OFF_IRQ_ENAB;
	endfunction : known_off

	assign nv_addr = {addr_high_reg, addr_low_reg};
	assign pgm_sel = control_reg[CB_PGM];
	// AXI write path: address and data taken independently
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_reg  <= 1'b0;
			aw_ok_reg    <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_addr_reg  <= 5'h00;
			w_data_reg   <= 8'h00;
			w_lane_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= word_off(s_axi_awaddr);
				aw_ok_reg   <= known_off(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= aw_ok_reg ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register write strobes
	logic wr_en;
	assign wr_en = wr_fire && w_lane_reg && aw_ok_reg;
	assign wr_req = wr_en && aw_addr_reg == OFF_CONTROL &&
		w_data_reg[CB_WR] && !control_reg[CB_WR] && !busy_reg;
	assign real_write = w_data_reg[CB_ERS] || !w_data_reg[CB_LATCH_LOAD_ONLY] ||
		!(w_data_reg[CB_PGM] || w_data_reg[CB_CFG]);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			unlock_reg <= UNLOCK_IDLE;
		end else if (wr_en && aw_addr_reg == OFF_UNLOCK) begin
			if (w_data_reg == UNLOCK_FIRST)
				unlock_reg <= UNLOCK_HALF;
			else if (w_data_reg == UNLOCK_SECOND &&
				unlock_reg == UNLOCK_HALF)
				unlock_reg <= UNLOCK_OPEN;
			else
				unlock_reg <= UNLOCK_IDLE;
		end else if (wr_en) begin
			unlock_reg <= UNLOCK_IDLE;
		end
	end

	// Start decode: unlocked, permitted, write-start set
	logic go;
	assign go = wr_req && unlock_reg == UNLOCK_OPEN && w_data_reg[CB_WEN];
	assign latch_pulse = go && !w_data_reg[CB_ERS] &&
		(w_data_reg[CB_PGM] || w_data_reg[CB_CFG]);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg     <= 1'b0;
			busy_cnt_reg <= '0;
		end else if (go && real_write) begin
			busy_reg     <= 1'b1;
			busy_cnt_reg <= 32'(PROG_CYCLES_P - 1);
		end else if (busy_reg) begin
			if (busy_cnt_reg == '0)
				busy_reg <= 1'b0;
			else
				busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
		end
	end
	assign cpu_halt = busy_reg;
	assign commit_pulse = busy_reg && busy_cnt_reg == '0;
	logic latch_done;
	assign latch_done = latch_pulse && w_data_reg[CB_LATCH_LOAD_ONLY];
	assign done_pulse = commit_pulse || latch_done;

	assign rd_pulse = control_reg[CB_RD];

	// Control register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			control_reg <= 8'h00;
		end else begin
			if (wr_en && aw_addr_reg == OFF_CONTROL) begin
				control_reg[7:4] <= w_data_reg[7:4];
				control_reg[CB_WEN] <= w_data_reg[CB_WEN];
				if (w_data_reg[CB_WR])
					control_reg[CB_ERR] <= 1'b1;
				else
					control_reg[CB_ERR] <= w_data_reg[CB_ERR];
				if (go && !latch_done)
					control_reg[CB_WR] <= 1'b1;
				if (w_data_reg[CB_RD] && !busy_reg)
					control_reg[CB_RD] <= 1'b1;
			end
			if (rd_pulse)
				control_reg[CB_RD] <= 1'b0;
			if (done_pulse)
				control_reg[CB_ERR] <= 1'b0;
			if (commit_pulse) begin
				control_reg[CB_WR] <= 1'b0;
				control_reg[CB_ERS] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_low_reg  <= 8'h00;
			data_high_reg <= 6'h00;
			addr_low_reg  <= 8'h00;
			addr_high_reg <= 7'h00;
		end else begin
			if (wr_en && aw_addr_reg == OFF_DATA_LOW)
				data_low_reg <= w_data_reg;
			if (wr_en && aw_addr_reg == OFF_DATA_HIGH)
				data_high_reg <= w_data_reg[5:0];
			if (wr_en && aw_addr_reg == OFF_ADDR_LOW)
				addr_low_reg <= w_data_reg;
			if (wr_en && aw_addr_reg == OFF_ADDR_HIGH)
				addr_high_reg <= w_data_reg[6:0] & ADDR_HIGH_MASK;
			if (rd_pulse) begin
				data_low_reg  <= st_addr_ok ? st_rdata[7:0] : 8'h00;
				data_high_reg <= st_addr_ok ? st_rdata[13:8] : 6'h00;
			end
		end
	end

	// completion flag, set wins over clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_flags_reg <= 8'h00;
			irq_enab_reg  <= 8'h00;
		end else begin
			if (wr_en && aw_addr_reg == OFF_IRQ_ENAB)
				irq_enab_reg[IRQ_DONE_BIT] <= w_data_reg[IRQ_DONE_BIT];
			if (done_pulse)
				irq_flags_reg[IRQ_DONE_BIT] <= 1'b1;
			else if (wr_en && aw_addr_reg == OFF_IRQ_FLAGS &&
				w_data_reg[IRQ_DONE_BIT])
				irq_flags_reg[IRQ_DONE_BIT] <= 1'b0;
		end
	end
	assign irq = |(irq_flags_reg & irq_enab_reg);

	// Read path; unlock port reads zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= known_off(s_axi_araddr) ? RESP_OKAY
				: RESP_SLVERR;
			if (!known_off(s_axi_araddr))
				s_axi_rdata <= 32'h0000_0000;
			else unique case (word_off(s_axi_araddr))
				OFF_DATA_LOW:  s_axi_rdata <= {24'h0, data_low_reg};
				OFF_DATA_HIGH: s_axi_rdata <= {26'h0, data_high_reg};
				OFF_ADDR_LOW:  s_axi_rdata <= {24'h0, addr_low_reg};
				OFF_ADDR_HIGH: s_axi_rdata <= {24'h0,
					ADDR_HIGH_TOP | {1'b0, addr_high_reg}};
				OFF_CONTROL:   s_axi_rdata <= {24'h0, control_reg};
				OFF_IRQ_FLAGS: s_axi_rdata <= {24'h0, irq_flags_reg};
				OFF_IRQ_ENAB:  s_axi_rdata <= {24'h0, irq_enab_reg};
				default:       s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	nvac_store u_store (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.rd_pulse     (rd_pulse),
		.latch_pulse  (latch_pulse),
		.commit_pulse (commit_pulse),
		.erase_sel    (control_reg[CB_ERS]),
		.pgm_sel      (pgm_sel),
		.cfg_sel      (control_reg[CB_CFG]),
		.addr         (nv_addr),
		.wdata        ({data_high_reg, data_low_reg}),
		.rdata        (st_rdata),
		.addr_ok      (st_addr_ok)
	);
endmodule : nvac_top

//--- nvac_checker.sv
// Bus and halt timing checker for the nv access control block
module nvac_checker
	import nvac_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
	// Clock and reset
	input wire logic		clk,
	input wire logic		sys_rst,
	// Bus handshakes
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic [31:0]	s_axi_araddr,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic		s_axi_rvalid,
	input wire logic		s_axi_rready,
	// CPU side
	input wire logic		cpu_halt
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	int hcnt;
	// Length of the running halt
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			hcnt <= 0;
		else
			hcnt <= cpu_halt ? hcnt + 1 : 0;
	end
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_at(logic [4:0] o);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == {27'h0, o};
	endsequence
	b_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response not held");
	dhigh_top_a: assert property (
		rd_at(OFF_DATA_HIGH) |=> s_axi_rdata[7:6] == 2'b00)
		else $error("data high top bits not zero");
	ahigh_top_a: assert property (
		rd_at(OFF_ADDR_HIGH) |=> s_axi_rdata[7])
		else $error("address high top bit not one");
	unlock_read_a: assert property (
		rd_at(OFF_UNLOCK) |=> s_axi_rdata == 32'h0)
		else $error("unlock port readable");
	unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > 32'h1C |=> s_axi_rresp == 2'b10)
		else $error("unmapped read not refused");
	halt_len_a: assert property (
		$fell(cpu_halt) |-> hcnt == PROG_CYCLES_P)
		else $error("halt length wrong");
endmodule : nvac_checker

bind nvac_top nvac_checker #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (
	.clk(clk), .sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .cpu_halt(cpu_halt)
);

//--- tb_top.sv
// Self-checking bench for the nv access control block
module tb_top
	import nvac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PC = 20;
	localparam int LIMIT = 6000;
	logic			clk, sys_rst, cpu_halt, irq;
	logic [31:0]	s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]		s_axi_wstrb;
	logic [1:0]		s_axi_bresp, s_axi_rresp, resp;
	logic			s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic			s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic			s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic			s_axi_rready;
	logic [7:0]		d;
	logic [31:0]	rdw;
	int				n_mismatch, n_tests, cyc, hcnt;

	nvac_top #(.PROG_CYCLES_P(PC)) dut (
		.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cpu_halt(cpu_halt), .irq(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task test_done();
		$display("mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// Watchdog and halt cycle count
	always @(posedge clk) begin
		cyc++;
		if (cpu_halt === 1'b1)
			hcnt++;
		if (cyc > LIMIT) begin
			n_mismatch++;
			test_done();
		end
	end

	function automatic logic [31:0] ad(input logic [4:0] o);
		return {27'h0, o};
	endfunction : ad

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [31:0] a, input logic [7:0] v);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			#1;
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	task rd(input logic [31:0] a);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			#1;
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rdw = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end while (!tr);
		d = rdw[7:0];
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	task rc(input logic [4:0] a, input logic [7:0] e, input string nm);
		rd(ad(a));
		chk(nm, {24'h0, e}, {24'h0, d});
	endtask : rc

	// Unlock, start, then count halt cycles
	task op(input logic [7:0] c, input int h);
		wr(ad(OFF_UNLOCK), UNLOCK_FIRST);
		wr(ad(OFF_UNLOCK), UNLOCK_SECOND);
		hcnt = 0;
		wr(ad(OFF_CONTROL), c);
		repeat (PC + 8) @(posedge clk);
		if (h >= 0)
			chk("halt cycles", h, hcnt);
	endtask : op

	initial begin
		sys_rst = 1'b1;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rc(OFF_ADDR_LOW, 8'h00, "al rst");
		rc(OFF_ADDR_HIGH, 8'h80, "ah rst");
		wr(ad(OFF_UNLOCK), UNLOCK_FIRST);
		rc(OFF_UNLOCK, 8'h00, "unlock");
		wr(ad(OFF_DATA_HIGH), 8'hFF);
		rc(OFF_DATA_HIGH, 8'h3F, "dh");
		wr(ad(OFF_ADDR_HIGH), 8'h7F);
		rc(OFF_ADDR_HIGH, 8'hFF, "ah");
		rd(32'h20);
		chk("ud resp", 2'b10, resp);
		chk("ud data", 32'h0, rdw);
		wr(32'h20, 8'h01);
		chk("uw resp", 2'b10, resp);
		wr(ad(OFF_ADDR_HIGH), 8'h00);
		wr(ad(OFF_ADDR_LOW), 8'h05);
		wr(ad(OFF_DATA_LOW), 8'h3C);
		wr(ad(OFF_CONTROL), 8'h04);
		op(8'h06, -1);
		rc(OFF_CONTROL, 8'h04, "ctl");
		rc(OFF_IRQ_FLAGS, 8'h10, "flag");
		chk("irq off", 1'b0, irq);
		wr(ad(OFF_IRQ_ENAB), 8'h10);
		chk("irq on", 1'b1, irq);
		wr(ad(OFF_IRQ_FLAGS), 8'h10);
		chk("irq clr", 1'b0, irq);
		wr(ad(OFF_DATA_LOW), 8'h00);
		wr(ad(OFF_CONTROL), 8'h01);
		rc(OFF_DATA_LOW, 8'h3C, "verify");
		rc(OFF_CONTROL, 8'h00, "rd clr");
		wr(ad(OFF_DATA_LOW), 8'h11);
		wr(ad(OFF_CONTROL), 8'h06);
		rd(ad(OFF_CONTROL));
		chk("err", 1'b1, d[3]);
		wr(ad(OFF_CONTROL), 8'h05);
		rc(OFF_DATA_LOW, 8'h3C, "locked");
		wr(ad(OFF_ADDR_LOW), 8'h10);
		wr(ad(OFF_DATA_LOW), 8'h5A);
		wr(ad(OFF_DATA_HIGH), 8'h2B);
		wr(ad(OFF_CONTROL), 8'hA4);
		op(8'hA6, 0);
		wr(ad(OFF_ADDR_LOW), 8'h11);
		wr(ad(OFF_DATA_LOW), 8'hC3);
		wr(ad(OFF_DATA_HIGH), 8'h01);
		wr(ad(OFF_CONTROL), 8'h84);
		op(8'h86, PC);
		wr(ad(OFF_CONTROL), 8'h81);
		rc(OFF_DATA_LOW, 8'hC3, "f11 l");
		wr(ad(OFF_ADDR_LOW), 8'h10);
		wr(ad(OFF_CONTROL), 8'h81);
		rc(OFF_DATA_LOW, 8'h5A, "f10 l");
		rc(OFF_DATA_HIGH, 8'h2B, "f10 h");
		wr(ad(OFF_CONTROL), 8'h94);
		op(8'h96, PC);
		rc(OFF_CONTROL, 8'h84, "ers clr");
		wr(ad(OFF_CONTROL), 8'h81);
		rc(OFF_DATA_LOW, 8'hFF, "ers l");
		rc(OFF_DATA_HIGH, 8'h3F, "ers h");
		wr(ad(OFF_CONTROL), 8'h80);
		op(8'h82, 0);
		rc(OFF_CONTROL, 8'h88, "no permit");
		wr(ad(OFF_ADDR_LOW), 8'h01);
		wr(ad(OFF_DATA_LOW), 8'h15);
		wr(ad(OFF_DATA_HIGH), 8'h07);
		wr(ad(OFF_CONTROL), 8'hC4);
		op(8'hC6, PC);
		wr(ad(OFF_CONTROL), 8'hC1);
		rc(OFF_DATA_LOW, 8'h15, "uid l");
		rc(OFF_DATA_HIGH, 8'h07, "uid h");
		wr(ad(OFF_ADDR_LOW), 8'h06);
		wr(ad(OFF_CONTROL), 8'hC1);
		rc(OFF_DATA_LOW, DEVICE_ID_WORD[7:0], "id l");
		rc(OFF_DATA_HIGH, {2'b00, DEVICE_ID_WORD[13:8]}, "id h");
		wr(ad(OFF_ADDR_LOW), 8'h04);
		wr(ad(OFF_CONTROL), 8'hC1);
		rc(OFF_DATA_LOW, 8'h00, "gap l");
		rc(OFF_DATA_HIGH, 8'h00, "gap h");
		test_done();
	end
endmodule : tb_top
